/* File: bench/tb_top.sv */
// Self-checking bench for the alarm status bank: register port, alarms, irq.
// Assumes the bank answers reads one cycle after the strobe and never stalls.
`timescale 1ns/10ps
`include "alarm_status_params.svh"

module tb_top;
  logic ref_clk, arst_n, wr_stb, rd_stb, irq;
  logic [7:0] addr, wdata, rdata, d;
  logic [15:0] word_a, word_b;
  logic alm_a, alm_b;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  alarm_status_bank alarm_status_bank_i (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .pll_offset_word_a(word_a), .pll_offset_word_b(word_b),
    .ref_input_a_alarm(alm_a), .ref_input_b_alarm(alm_b), .irq(irq));

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Hang guard: the whole run needs under a hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checked %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Interrupt line is a single level, judged apart from register bytes
  task automatic chk_irq(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected irq at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic t_reset();
    rd(`OFS_ALARM_STS, d); chk(d, 8'h22);
    rd(8'h55, d); chk(d, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_freq();
    rd(`OFS_FREQ_HIGH, d); chk(d, 8'h81);
    wr(`OFS_SRC_SELECT, 8'h10);
    rd(`OFS_FREQ_HIGH, d); chk(d, 8'h7f);
    wr(`OFS_SRC_SELECT, 8'hef);
    rd(`OFS_FREQ_HIGH, d); chk(d, 8'h81);
    $display("frequency test done");
  endtask

  // Alarms are still high, so a write that sticks is told apart from the live value
  task automatic t_test_mode();
    wr(`OFS_ALARM_STS, 8'h00);
    rd(`OFS_ALARM_STS, d); chk(d, 8'h22);
    wr(`OFS_TEST_CTRL, 8'h01);
    wr(`OFS_ALARM_STS, 8'h00);
    rd(`OFS_ALARM_STS, d); chk(d, 8'h00);
    wr(`OFS_ALARM_STS, 8'hff);
    rd(`OFS_ALARM_STS, d); chk(d, 8'h22);
    wr(`OFS_TEST_CTRL, 8'h00);
    $display("test mode test done");
  endtask

  task automatic t_alarms();
    alm_a <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(`OFS_ALARM_STS, d); chk(d, 8'h20);
    @(posedge ref_clk);
    alm_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(`OFS_ALARM_STS, d); chk(d, 8'h00);
    @(posedge ref_clk);
    alm_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(`OFS_ALARM_STS, d); chk(d, 8'h20);
    $display("alarm test done");
  endtask

  // Input a rises in the very cycle of a clear, so the event must survive it
  task automatic t_irq();
    wr(`OFS_IRQ_CLR, 8'h03);
    wr(`OFS_IRQ_EN, 8'h03);
    repeat (2) @(posedge ref_clk);
    #1 chk_irq(irq, 1'b0);
    @(posedge ref_clk);
    alm_a <= 1'b1;
    @(posedge ref_clk);
    wr(`OFS_IRQ_CLR, 8'h01);
    repeat (4) @(posedge ref_clk);
    #1 chk_irq(irq, 1'b1);
    rd(`OFS_IRQ_STS, d); chk(d, 8'h01);
    wr(`OFS_IRQ_EN, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1 chk_irq(irq, 1'b0);
    wr(`OFS_IRQ_CLR, 8'h01);
    rd(`OFS_IRQ_STS, d); chk(d, 8'h00);
    rd(`OFS_ALARM_STS, d); chk(d, 8'h22);
    $display("interrupt test done");
  endtask

  // Alarms held high through reset keep the status at its reset value
  initial begin
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    word_a = 16'h8123;
    word_b = 16'h7f45;
    alm_a = 1'b1;
    alm_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_freq();
    t_test_mode();
    t_alarms();
    t_irq();
    summarize();
  end
endmodule // tb_top

/* File: common/alarm_status_params.svh */
// Register offsets, field positions and reset values of the alarm status bank.
// Assumes an 8-bit register port with byte-wide offsets.
`ifndef ALARM_STATUS_PARAMS_SVH
`define ALARM_STATUS_PARAMS_SVH

`define ADDR_W 8
`define DATA_W 8
`define OFS_FREQ_HIGH 8'h0d
`define OFS_ALARM_STS 8'h11
`define OFS_SRC_SELECT 8'h4b
`define OFS_IRQ_STS 8'h60
`define OFS_IRQ_CLR 8'h61
`define OFS_IRQ_EN 8'h62
`define OFS_TEST_CTRL 8'h63
`define BIT_LOOP_CHOICE 4
`define BIT_ALARM_A 1
`define BIT_ALARM_B 5
`define BIT_TEST_MODE 0
`define ALARM_STS_RESET 8'h22
`define ALARM_STS_MASK 8'h22
`define IRQ_W 2
`define IRQ_BIT_A 0
`define IRQ_BIT_B 1
`define SYNC_RESET_VAL 2'h3

`endif

/* File: common/alarm_status_pkg.sv */
// Types of the alarm status bank: the one packed state record.
// Assumes alarm_status_params.svh is included before use of the widths.
`include "alarm_status_params.svh"

package alarm_status_pkg;

  typedef struct packed {
    logic [`DATA_W-1:0] alarm_sts;
    logic [`DATA_W-1:0] src_select;
    logic test_mode;
    logic [`IRQ_W-1:0] irq_sts;
    logic [`IRQ_W-1:0] irq_en;
    logic [`IRQ_W-1:0] alarm_prev;
    logic [`DATA_W-1:0] rdata;
  } bank_state_t;

endpackage

/* File: verilog/alarm_status_bank.sv */
// Status bank: loop frequency-offset high byte and reference no-activity alarms.
// Assumes offset words arrive on ref_clk; alarm levels come from another domain.
// Function
// - Read-only byte shows bits 15:8 of the loop frequency-offset word.
// - Source-select bit 4 low reports first loop, high reports second loop.
// - Alarm byte read-only normally, writable in test mode, resets to 0x22.
// - Outside test mode, alarm byte follows the alarms currently raised by the activity monitors.
// - Bit 1 is high while reference input a has an alarm, bit 5 for input b; others unused.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "alarm_status_params.svh"

module alarm_status_bank (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [`DATA_W-1:0] rdata,
  input wire logic [15:0] pll_offset_word_a,
  input wire logic [15:0] pll_offset_word_b,
  input wire logic ref_input_a_alarm,
  input wire logic ref_input_b_alarm,
  output logic irq
);

  // Reset is asserted at once, released only after two clean edges
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Alarms start high so the bank reads as alarmed until monitors settle
  logic [1:0] alarm_s;
  sync_bits #(
    .WIDTH(2),
    .RESET_VAL(`SYNC_RESET_VAL)
  ) u_alarm_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .async_in({ref_input_b_alarm, ref_input_a_alarm}),
    .sync_out(alarm_s)
  );

  // Offset decode is used for the write path; the read path decodes addr in its own case
  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  alarm_status_pkg::bank_state_t st_q;
  alarm_status_pkg::bank_state_t st_d;
  logic [7:0] freq_high;
  logic [`DATA_W-1:0] live_alarm;
  logic [`IRQ_W-1:0] alarm_rise;
  logic [`IRQ_W-1:0] clr_mask;

  // Layout guard: flags and alarm bits must leave room inside one data byte,
  // otherwise the zero padding of the read-back words would have no width
  if (`IRQ_W >= `DATA_W || `BIT_ALARM_B >= `DATA_W) begin : g_bad_layout
    $error("alarm status layout does not fit the data byte");
  end

  // Loop choice picks which offset word feeds the high byte
  always_comb begin
    if (st_q.src_select[`BIT_LOOP_CHOICE]) begin
      freq_high = pll_offset_word_b[15:8];
    end else begin
      freq_high = pll_offset_word_a[15:8];
    end
  end

  // Only bits 5 and 1 carry alarms; unused bits stay zero
  always_comb begin
    live_alarm = '0;
    live_alarm[`BIT_ALARM_B] = alarm_s[1];
    live_alarm[`BIT_ALARM_A] = alarm_s[0];
  end

  assign alarm_rise = alarm_s & ~st_q.alarm_prev;
  assign clr_mask = (wr_stb && hit(addr, `OFS_IRQ_CLR)) ? wdata[`IRQ_W-1:0] : '0;

  // Next state of the whole bank
  always_comb begin
    st_d = st_q;
    st_d.alarm_prev = alarm_s;
    // Test mode freezes the live view so software can plant a pattern
    if (!st_q.test_mode) begin
      st_d.alarm_sts = live_alarm;
    end else if (wr_stb && hit(addr, `OFS_ALARM_STS)) begin
      st_d.alarm_sts = wdata & `ALARM_STS_MASK;
    end
    if (wr_stb && hit(addr, `OFS_SRC_SELECT)) begin
      st_d.src_select = wdata;
    end
    if (wr_stb && hit(addr, `OFS_TEST_CTRL)) begin
      st_d.test_mode = wdata[`BIT_TEST_MODE];
    end
    if (wr_stb && hit(addr, `OFS_IRQ_EN)) begin
      st_d.irq_en = wdata[`IRQ_W-1:0];
    end
    // A new alarm in the clearing cycle survives the clear
    st_d.irq_sts = (st_q.irq_sts & ~clr_mask) | {alarm_rise[1], alarm_rise[0]};
    // Read data stand for one cycle only, zero otherwise
    st_d.rdata = '0;
    if (rd_stb) begin
      case (addr)
        `OFS_FREQ_HIGH: st_d.rdata = freq_high;
        `OFS_ALARM_STS: st_d.rdata = st_q.alarm_sts;
        `OFS_SRC_SELECT: st_d.rdata = st_q.src_select;
        `OFS_IRQ_STS: st_d.rdata = {{(`DATA_W-`IRQ_W){1'b0}}, st_q.irq_sts};
        `OFS_IRQ_EN: st_d.rdata = {{(`DATA_W-`IRQ_W){1'b0}}, st_q.irq_en};
        `OFS_TEST_CTRL: st_d.rdata = {{(`DATA_W-1){1'b0}}, st_q.test_mode};
        default: st_d.rdata = '0;
      endcase
    end
  end

  // Single register for the whole bank
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.alarm_sts <= `ALARM_STS_RESET;
      st_q.src_select <= 8'h00;
      st_q.test_mode <= 1'b0;
      st_q.irq_sts <= 2'h0;
      st_q.irq_en <= 2'h0;
      st_q.alarm_prev <= `SYNC_RESET_VAL;
      st_q.rdata <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign irq = |(st_q.irq_sts & st_q.irq_en);

  // Helper: first cycle after reset release
  logic seen_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  a_freq_byte_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_stb && hit(addr, `OFS_FREQ_HIGH) |=> rdata == ($past(st_q.src_select[4]) ?
      $past(pll_offset_word_b[15:8]) : $past(pll_offset_word_a[15:8])))
    else $error("frequency byte does not follow loop choice");

  a_freq_sign_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_stb && hit(addr, `OFS_FREQ_HIGH) && !st_q.src_select[4] |=>
      rdata[7] == $past(pll_offset_word_a[15]))
    else $error("sign bit of offset word lost");

  a_freq_high_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_stb && hit(addr, `OFS_FREQ_HIGH) && st_q.src_select[4] |=>
      rdata == $past(pll_offset_word_b[15:8]))
    else $error("frequency byte is not bits 15 to 8");

  a_status_reset_val: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !seen_q |-> st_q.alarm_sts == 8'h22)
    else $error("alarm status reset value wrong");

  a_status_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st_q.test_mode ##1 !$past(st_q.test_mode) |-> st_q.alarm_sts == $past(live_alarm))
    else $error("alarm status does not follow monitors");

  // Alarm path: status bit and event flag move on the same edge
  a_alarm_b_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st_q.test_mode && $rose(alarm_s[1]) |=> st_q.alarm_sts[5] && st_q.irq_sts[1])
    else $error("input b alarm not shown");

  a_alarm_a_unused: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st_q.test_mode |=> st_q.alarm_sts[1] == $past(alarm_s[0]) &&
      (st_q.alarm_sts & 8'hdd) == 8'h00)
    else $error("input a alarm or unused bits wrong");

  // Read port: data stand one cycle only, then the port idles at zero
  a_rdata_idle_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rd_stb |=> rdata == 8'h00)
    else $error("read data left standing without a read");

  a_src_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_stb && hit(addr, `OFS_SRC_SELECT) |=> st_q.src_select == $past(wdata))
    else $error("loop choice write not stored");

  // Test mode: only a write to the status byte may change it
  a_test_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_q.test_mode && wr_stb && hit(addr, `OFS_ALARM_STS) |=>
      st_q.alarm_sts == ($past(wdata) & `ALARM_STS_MASK))
    else $error("test mode write to alarm status lost");

  a_test_mode_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_q.test_mode && !(wr_stb && hit(addr, `OFS_ALARM_STS)) |=>
      $stable(st_q.alarm_sts))
    else $error("alarm status moved in test mode");

  a_alarm_a_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st_q.test_mode && $rose(alarm_s[0]) |=> st_q.alarm_sts[1] && st_q.irq_sts[0])
    else $error("input a alarm not shown");

  // Interrupt flags: a fresh event outranks a clear in the same cycle
  a_irq_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_stb && hit(addr, `OFS_IRQ_CLR) && alarm_rise[0] |=> st_q.irq_sts[0])
    else $error("clear swallowed a new input a event");

  a_irq_clear_works: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_stb && hit(addr, `OFS_IRQ_CLR) && wdata[0] && !alarm_rise[0] |=>
      !st_q.irq_sts[0])
    else $error("input a event flag not cleared");

endmodule // alarm_status_bank

/* File: verilog/sync_bits.sv */
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherence between bits.
`timescale 1ns/10ps

module sync_bits #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Refused at elaboration: a zero-width group has nothing to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("sync_bits needs at least one bit");
  end

  // One pair of flops per bit; the first flop feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= RESET_VAL[i];
          stable_q <= RESET_VAL[i];
        end else begin
          meta_q <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule // sync_bits
